// file: core/clkwake_pkg.sv
package clkwake_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_REG_CTL = 8'h00;
    localparam logic [7:0] ADDR_PLL_DIV = 8'h04;
    localparam logic [7:0] ADDR_PLL_MUL = 8'h08;
    localparam logic [7:0] ADDR_SDRAM_GC = 8'h0C;
    localparam logic [7:0] ADDR_ASYNC_GC = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int REGULATOR_FREQUENCY_FIELD_LSB = 0;
    localparam int LEVEL_LSB = 4;
    localparam int BUFFERED_INPUT_CLOCK_OUT_EN_BIT = 8;
    localparam int RTC_WAKE_BIT = 9;
    localparam int USB_WAKE_BIT = 10;
    localparam int ETH_WAKE_BIT = 11;
    localparam int SSEL_LSB = 0;
    localparam int CSEL_LSB = 4;
    localparam int MUL_LSB = 0;
    localparam int SYSTEM_CLOCK_OUT_EN_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] REGULATOR_FREQUENCY_FIELD_RST = 2'h3;
    localparam logic [3:0] LEVEL_RST = 4'h8;
    localparam logic [3:0] SSEL_RST = 4'h5;
    localparam logic [1:0] CSEL_RST = 2'h0;
    localparam logic [5:0] MUL_RST = 6'h0A;
    localparam logic [6:0] PIN_RST = 7'h11;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int VOLT_STEP_MV = 50;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SOFTSTART_NS = 1000;
    localparam int SOFTSTART_CYC = (SOFTSTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] STRAP_SETTLE = 3'h5;

    typedef enum logic [3:0] {
        ST_ON = 4'b0001,
        ST_DOWN = 4'b0010,
        ST_WAIT_PG = 4'b0100,
        ST_BOOT = 4'b1000
    } pwr_state_t;

endpackage : clkwake_pkg

// file: core/clock_wake_ctrl.sv
`timescale 1ns/1ps
module clock_wake_ctrl
    import clkwake_pkg::*;
#(
    parameter int SOFTSTART_CYCLES = SOFTSTART_CYC
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Pins in
    input wire logic input_clock,
    input wire logic regulator_mode_select_pin,
    input wire logic rtc_wake,
    input wire logic usb_wake,
    input wire logic eth_wake,
    input wire logic reset_pin_n,
    // Shared soft-start / power-good pin
    input wire logic softstart_powergood_in,
    output logic softstart_powergood_out,
    output logic softstart_powergood_oe,
    // Power outputs
    output logic first_wake_output,
    output logic regulator_drive_output,
    output logic core_supply_en,
    output logic [3:0] core_voltage_code,
    output logic boot_start,
    // Clock outputs
    output logic buffered_input_clock_out,
    output logic system_clock_out,
    output logic core_clock,
    output logic [5:0] pll_multiplier
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [3:0] div_count(input logic [3:0] cnt, input logic [3:0] div);
        logic [3:0] nxt;
        nxt = cnt + 4'h1;
        return (nxt >= div) ? 4'h0 : nxt;
    endfunction : div_count

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] pins_in;
    logic [6:0] s1_q;
    logic [6:0] s2_q;
    logic [6:0] s3_q;
    logic [6:0] filt_q;

    assign pins_in = {input_clock, regulator_mode_select_pin, softstart_powergood_in,
                      rtc_wake, usb_wake, eth_wake, reset_pin_n};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= PIN_RST;
            s2_q <= PIN_RST;
            s3_q <= PIN_RST;
            filt_q <= PIN_RST;
        end
        else
        begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change taken once second and third stage agree
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
        end
    end

    // ------------------------------------------------------------
    // Mode strap capture after reset release
    // ------------------------------------------------------------
    logic [2:0] strap_cnt_q;
    logic strap_done_q;
    logic ext_mode_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            strap_cnt_q <= 3'h0;
            strap_done_q <= 1'b0;
            ext_mode_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            strap_cnt_q <= strap_cnt_q + 3'h1;
            if (strap_cnt_q == STRAP_SETTLE)
            begin
                strap_done_q <= 1'b1;
                ext_mode_q <= filt_q[5];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic acc;
    logic wr_q;
    logic rd1_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_word;

    assign acc = hsel & hready & htrans[1];
    assign hreadyout = ~rd1_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            rd1_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wr_q <= acc & hwrite & (hsize == 3'h2);
            rd1_q <= acc & ~hwrite;
            if (acc)
                addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0000_0000;
        else if (rd1_q)
            hrdata_q <= rd_word;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] regulator_frequency_field_q;
    logic [3:0] level_q;
    logic buffered_input_clock_out_en_q;
    logic [2:0] wake_en_q;
    logic [3:0] ssel_q;
    logic [1:0] csel_q;
    logic [5:0] mul_q;
    logic sdram_ck_q;
    logic async_ck_q;
    pwr_state_t state_q;
    logic wake_any;
    logic wake_restore;
    logic pg_ok;
    logic supply_on;

    logic wr_ctl;
    assign wr_ctl = wr_q & (addr_q == ADDR_REG_CTL);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            regulator_frequency_field_q <= REGULATOR_FREQUENCY_FIELD_RST;
            level_q <= LEVEL_RST;
            buffered_input_clock_out_en_q <= 1'b1;
            wake_en_q <= 3'h0;
        end
        else
        begin
            if (wr_ctl)
            begin
                regulator_frequency_field_q <= hwdata[REGULATOR_FREQUENCY_FIELD_LSB +: 2];
                level_q <= hwdata[LEVEL_LSB +: 4];
                buffered_input_clock_out_en_q <= hwdata[BUFFERED_INPUT_CLOCK_OUT_EN_BIT];
                wake_en_q <= {hwdata[ETH_WAKE_BIT], hwdata[USB_WAKE_BIT], hwdata[RTC_WAKE_BIT]};
            end
            // Wake restores a running frequency; it wins over a write
            if (wake_restore)
                regulator_frequency_field_q <= REGULATOR_FREQUENCY_FIELD_RST;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ssel_q <= SSEL_RST;
            csel_q <= CSEL_RST;
            mul_q <= MUL_RST;
            sdram_ck_q <= 1'b1;
            async_ck_q <= 1'b1;
        end
        else if (wr_q)
        begin
            if (addr_q == ADDR_PLL_DIV)
            begin
                // Zero is no legal divisor, keep previous setting
                if (hwdata[SSEL_LSB +: 4] != 4'h0)
                    ssel_q <= hwdata[SSEL_LSB +: 4];
                csel_q <= hwdata[CSEL_LSB +: 2];
            end
            if (addr_q == ADDR_PLL_MUL)
                mul_q <= hwdata[MUL_LSB +: 6];
            if (addr_q == ADDR_SDRAM_GC)
                sdram_ck_q <= hwdata[SYSTEM_CLOCK_OUT_EN_BIT];
            if (addr_q == ADDR_ASYNC_GC)
                async_ck_q <= hwdata[SYSTEM_CLOCK_OUT_EN_BIT];
        end
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (addr_q)
            ADDR_REG_CTL:
            begin
                rd_word[REGULATOR_FREQUENCY_FIELD_LSB +: 2] = regulator_frequency_field_q;
                rd_word[LEVEL_LSB +: 4] = level_q;
                rd_word[BUFFERED_INPUT_CLOCK_OUT_EN_BIT] = buffered_input_clock_out_en_q;
                rd_word[RTC_WAKE_BIT] = wake_en_q[0];
                rd_word[USB_WAKE_BIT] = wake_en_q[1];
                rd_word[ETH_WAKE_BIT] = wake_en_q[2];
            end
            ADDR_PLL_DIV:
            begin
                rd_word[SSEL_LSB +: 4] = ssel_q;
                rd_word[CSEL_LSB +: 2] = csel_q;
            end
            ADDR_PLL_MUL: rd_word[MUL_LSB +: 6] = mul_q;
            ADDR_SDRAM_GC: rd_word[SYSTEM_CLOCK_OUT_EN_BIT] = sdram_ck_q;
            ADDR_ASYNC_GC: rd_word[SYSTEM_CLOCK_OUT_EN_BIT] = async_ck_q;
            ADDR_STATUS: rd_word[6:0] = {state_q, pg_ok, ext_mode_q, supply_on};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Power sequencer
    // ------------------------------------------------------------
    logic [5:0] ss_cnt_q;
    logic boot_q;

    assign pg_ok = ~filt_q[4];
    assign supply_on = (state_q != ST_DOWN);
    // Reset pin wake is always armed
    assign wake_any = (filt_q[3] & wake_en_q[0]) | (filt_q[2] & wake_en_q[1]) |
                      (filt_q[1] & wake_en_q[2]) | ~filt_q[0];
    assign wake_restore = (state_q == ST_DOWN) & wake_any;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= ST_ON;
            ss_cnt_q <= 6'h00;
            boot_q <= 1'b0;
        end
        else
        begin
            boot_q <= 1'b0;
            case (state_q)
                ST_ON:
                    if (regulator_frequency_field_q == 2'h0)
                        state_q <= ST_DOWN;
                ST_DOWN:
                    if (wake_any)
                    begin
                        ss_cnt_q <= 6'h00;
                        state_q <= ext_mode_q ? ST_WAIT_PG : ST_BOOT;
                    end
                ST_WAIT_PG:
                    if (pg_ok)
                    begin
                        boot_q <= 1'b1;
                        state_q <= ST_ON;
                    end
                ST_BOOT:
                begin
                    ss_cnt_q <= ss_cnt_q + 6'h01;
                    if (ss_cnt_q == 6'(SOFTSTART_CYCLES - 1))
                    begin
                        boot_q <= 1'b1;
                        state_q <= ST_ON;
                    end
                end
                default: state_q <= ST_ON;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Regulator pins
    // ------------------------------------------------------------
    logic [3:0] pwm_cnt_q;
    logic wake1_q;
    logic drive_q;
    logic ss_out_q;
    logic supply_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_cnt_q <= 4'h0;
            wake1_q <= 1'b1;
            drive_q <= 1'b0;
            ss_out_q <= 1'b0;
            supply_q <= 1'b1;
        end
        else
        begin
            pwm_cnt_q <= pwm_cnt_q + 4'h1;
            wake1_q <= supply_on;
            supply_q <= supply_on;
            // External mode: drive pin carries the second wake level
            drive_q <= ext_mode_q ? supply_on : (supply_on & (pwm_cnt_q < level_q));
            ss_out_q <= supply_on;
        end
    end

    assign first_wake_output = wake1_q;
    assign regulator_drive_output = drive_q;
    assign core_supply_en = supply_q;
    assign core_voltage_code = level_q;
    assign boot_start = boot_q;
    assign softstart_powergood_out = ss_out_q;
    assign softstart_powergood_oe = ~ext_mode_q;
    assign pll_multiplier = mul_q;

    // ------------------------------------------------------------
    // Clock dividers
    // ------------------------------------------------------------
    logic [3:0] sys_cnt_q;
    logic [3:0] sys_div_q;
    logic [3:0] core_cnt_q;
    logic [3:0] core_div_q;
    logic sys_wrap;
    logic core_wrap;
    logic sys_out_q;
    logic core_out_q;
    logic buffered_input_clock_out_q;

    assign sys_wrap = (sys_cnt_q == sys_div_q - 4'h1);
    assign core_wrap = (core_cnt_q == core_div_q - 4'h1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sys_cnt_q <= 4'h0;
            sys_div_q <= SSEL_RST;
            core_cnt_q <= 4'h0;
            core_div_q <= 4'h1;
        end
        else
        begin
            sys_cnt_q <= div_count(sys_cnt_q, sys_div_q);
            core_cnt_q <= div_count(core_cnt_q, core_div_q);
            // New ratio only at period end, no relock, no runt
            if (sys_wrap)
                sys_div_q <= ssel_q;
            if (core_wrap)
                core_div_q <= 4'h1 << csel_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sys_out_q <= 1'b0;
            core_out_q <= 1'b0;
            buffered_input_clock_out_q <= 1'b0;
        end
        else
        begin
            sys_out_q <= sys_wrap & supply_on & (sdram_ck_q | async_ck_q);
            core_out_q <= core_wrap & supply_on;
            buffered_input_clock_out_q <= filt_q[6] & buffered_input_clock_out_en_q;
        end
    end

    assign system_clock_out = sys_out_q;
    assign core_clock = core_out_q;
    assign buffered_input_clock_out = buffered_input_clock_out_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_regulator_frequency_field_zero_down: assert property ((state_q == ST_ON && regulator_frequency_field_q == 2'h0) |=> state_q == ST_DOWN)
        else $error("zero frequency did not power down");
    a_down_wakes_low: assert property ((state_q == ST_DOWN) |=> (!first_wake_output && !core_supply_en))
        else $error("wake output high in power-down");
    a_wake_leaves_down: assert property ((state_q == ST_DOWN && wake_any) |=> (state_q != ST_DOWN && regulator_frequency_field_q != 2'h0))
        else $error("wake did not leave power-down");
    a_pg_holds_off: assert property ((state_q == ST_WAIT_PG && !pg_ok) |=> (state_q == ST_WAIT_PG && !boot_start))
        else $error("started before power good");
    a_second_wake: assert property ((strap_done_q && ext_mode_q && $stable(ext_mode_q)) |-> regulator_drive_output == first_wake_output)
        else $error("second wake differs from first");
    a_sys_div_six: assert property ((sys_wrap && ssel_q == 4'h6) |=> !sys_wrap[*5] ##1 sys_wrap)
        else $error("system divide by six wrong");
    a_div_at_edge: assert property (!$past(sys_wrap) |-> $stable(sys_div_q))
        else $error("system divider changed mid period");
    a_core_div_eight: assert property ((core_wrap && csel_q == 2'h3) |=> !core_wrap[*7] ##1 core_wrap)
        else $error("core divide by eight wrong");
    a_buffered_input_clock_out_off: assert property ((!buffered_input_clock_out_en_q) |=> !buffered_input_clock_out)
        else $error("buffered clock not disabled");
    a_system_clock_out_off: assert property ((!sdram_ck_q && !async_ck_q) |=> !system_clock_out)
        else $error("system clock output not disabled");

endmodule : clock_wake_ctrl

// file: bench/regulator_model.sv
`timescale 1ns/1ps
module regulator_model
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Strap choice and wake lines
    input wire logic ext_mode,
    input wire logic wake_a,
    input wire logic wake_b,
    input wire logic [7:0] ramp_cycles,
    // Board outputs
    output logic mode_pin,
    output logic power_good_n,
    output logic input_clock
);
    int ramp_q;

    // Strap: high selects external, low internal
    assign mode_pin = ext_mode;

    // Free-running crystal, unrelated to hclk
    initial input_clock = 1'b0;
    always #173 input_clock = ~input_clock;

    // Supply ramps only while both lines request power
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ramp_q <= 0;
        else if (!(wake_a && wake_b))
            ramp_q <= 0;
        else if (ramp_q < 255)
            ramp_q <= ramp_q + 1;
    end

    // Good (low) only after the ramp has run out
    assign power_good_n = !(wake_a && wake_b && ramp_q >= int'(ramp_cycles));
endmodule : regulator_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench
    import clkwake_pkg::*;
;
    localparam int SS_CYC = 2;
    // ----------------
    // Signals
    // ----------------
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic input_clock;
    logic mode_pin;
    logic ext_mode;
    logic [7:0] ramp;
    logic rtc_wake;
    logic usb_wake;
    logic eth_wake;
    logic reset_pin_n;
    logic pg_n;
    logic ss_out;
    logic ss_oe;
    logic ss_pin;
    logic first_wake;
    logic reg_drive;
    logic supply_en;
    logic [3:0] volt_code;
    logic boot_start;
    logic buf_clk;
    logic sys_clk;
    logic core_clk;
    logic [5:0] pll_mul;
    logic probe;
    int probe_sel;
    int n_errors;
    int compares;
    int k;
    logic [31:0] r;
    logic [3:0] lvl;
    logic [5:0] mul;
    logic [3:0] ssel;
    logic [1:0] csel;

    initial hclk = 1'b0;
    always #25 hclk = ~hclk;

    // Shared pin level from both drivers
    assign ss_pin = ss_oe ? ss_out : pg_n;
    assign probe = (probe_sel == 0) ? sys_clk : (probe_sel == 1) ? buf_clk : core_clk;

    clock_wake_ctrl #(.SOFTSTART_CYCLES(SS_CYC)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .input_clock(input_clock), .regulator_mode_select_pin(mode_pin),
        .rtc_wake(rtc_wake), .usb_wake(usb_wake), .eth_wake(eth_wake),
        .reset_pin_n(reset_pin_n), .softstart_powergood_in(ss_pin),
        .softstart_powergood_out(ss_out), .softstart_powergood_oe(ss_oe),
        .first_wake_output(first_wake), .regulator_drive_output(reg_drive),
        .core_supply_en(supply_en), .core_voltage_code(volt_code), .boot_start(boot_start),
        .buffered_input_clock_out(buf_clk), .system_clock_out(sys_clk),
        .core_clock(core_clk), .pll_multiplier(pll_mul));

    regulator_model partner (.hclk(hclk), .hresetn(hresetn), .ext_mode(ext_mode),
        .wake_a(first_wake), .wake_b(reg_drive), .ramp_cycles(ramp), .mode_pin(mode_pin),
        .power_good_n(pg_n), .input_clock(input_clock));

    // ----------------
    // Tasks
    // ----------------
    task automatic stop_test;
        $display("Errors %0d, comparisons %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic hang;
        n_errors++;
        $display("MISMATCH wait expected response seen none");
        stop_test();
    endtask : hang

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic edge_ready(inout int n);
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20)
            hang();
    endtask : edge_ready

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [2:0] sz);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= sz;
        edge_ready(n);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        n = 0;
        edge_ready(n);
        r = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 3'b010);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h00000000, 3'b010);
    endtask : rd

    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (10) @(posedge hclk);
    endtask : do_reset

    task automatic wait_pulse(output int g);
        g = 0;
        do
        begin
            @(posedge hclk);
            g++;
        end
        while (probe !== 1'b1 && g < 64);
        if (g >= 64)
            hang();
    endtask : wait_pulse

    task automatic measure(input logic [31:0] exp);
        int g;
        repeat (3) wait_pulse(g);
        check("period", g, exp);
    endtask : measure

    task automatic count_hi(output int c);
        c = 0;
        repeat (4) @(posedge hclk);
        repeat (48)
        begin
            @(posedge hclk);
            c += int'(probe === 1'b1);
        end
    endtask : count_hi

    task automatic set_wake(input int s, input logic v);
        if (s == 0)
            rtc_wake <= v;
        else if (s == 1)
            usb_wake <= v;
        else if (s == 2)
            eth_wake <= v;
        else
            reset_pin_n <= !v;
    endtask : set_wake

    task automatic power_cycle(input int s);
        int t;
        int g;
        logic [31:0] en;
        en = (s < 3) ? (32'h1 << (RTC_WAKE_BIT + s)) : 32'h0;
        wr(ADDR_REG_CTL, 32'h00000180 | en);
        repeat (6) @(posedge hclk);
        check("first_wake_down", first_wake, 1'b0);
        check("second_wake_down", reg_drive, 1'b0);
        check("supply_down", supply_en, 1'b0);
        if (!ext_mode)
            check("softstart_down", ss_out, 1'b0);
        rd(ADDR_STATUS);
        check("state_down", r[6:3], 4'h2);
        set_wake((s + 1) % 3, 1'b1);
        repeat (12) @(posedge hclk);
        check("disabled_wake", supply_en, 1'b0);
        set_wake((s + 1) % 3, 1'b0);
        set_wake(s, 1'b1);
        t = 0;
        g = 0;
        while (boot_start !== 1'b1 && t < 400)
        begin
            @(posedge hclk);
            t++;
            g = (first_wake === 1'b1) ? g + 1 : 0;
        end
        check("boot", boot_start, 1'b1);
        if (ext_mode)
            check("pg_hold", g > int'(ramp), 1'b1);
        repeat (2) @(posedge hclk);
        check("first_wake_up", first_wake, 1'b1);
        check("supply_up", supply_en, 1'b1);
        if (ext_mode)
            check("second_wake_up", reg_drive, 1'b1);
        else
            check("softstart_up", ss_out, 1'b1);
        set_wake(s, 1'b0);
        rd(ADDR_REG_CTL);
        check("regulator_frequency_field_back", r[1:0], 2'h3);
    endtask : power_cycle

    // ----------------
    // Sequence
    // ----------------
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        rtc_wake = 1'b0;
        usb_wake = 1'b0;
        eth_wake = 1'b0;
        reset_pin_n = 1'b1;
        ext_mode = 1'b0;
        ramp = 8'h02;
        probe_sel = 0;
        n_errors = 0;
        compares = 0;
        void'($urandom(25));
        do_reset();
        check("level_rst", volt_code, 4'h8);
        check("mul_rst", pll_mul, 6'h0A);
        check("wake_rst", first_wake, 1'b1);
        check("oe_internal", ss_oe, 1'b1);
        check("resp", hresp, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            rd(8'(i * 4));
            k = (i == 0) ? 32'h183 : (i == 1) ? 32'h5 : (i == 2) ? 32'hA : 32'h1;
            if (i == 5)
                check("status_rst", r & 32'h7B, 32'h09);
            else
                check("reg_rst", r, k);
        end
        rd(8'h18);
        check("unmapped", r, 32'h0);
        repeat (6)
        begin
            lvl = 4'($urandom_range(15));
            mul = 6'($urandom_range(63));
            wr(ADDR_REG_CTL, 32'h103 | (32'(lvl) << LEVEL_LSB));
            wr(ADDR_PLL_MUL, 32'(mul));
            rd(ADDR_REG_CTL);
            check("ctl", r, 32'h103 | (32'(lvl) << LEVEL_LSB));
            check("level", volt_code, lvl);
            check("mul", pll_mul, mul);
        end
        bus(1'b1, ADDR_PLL_MUL, 32'h3F, 3'b000);
        rd(ADDR_PLL_MUL);
        check("byte_write", r, 32'(mul));
        for (int i = 0; i < 7; i++)
        begin
            ssel = (i == 0) ? 4'h1 : (i == 1) ? 4'h6 : (i == 2) ? 4'hF : 4'($urandom_range(15, 1));
            csel = 2'(i);
            wr(ADDR_PLL_DIV, {26'h0, csel, ssel});
            probe_sel = 0;
            measure(32'(ssel));
            probe_sel = 2;
            measure(32'h1 << csel);
        end
        wr(ADDR_PLL_DIV, 32'h0);
        rd(ADDR_PLL_DIV);
        check("div_zero", r, {26'h0, 2'h0, ssel});
        wr(ADDR_SDRAM_GC, 32'h0);
        wr(ADDR_ASYNC_GC, 32'h0);
        probe_sel = 0;
        count_hi(k);
        check("system_clock_out_off", k, 32'h0);
        wr(ADDR_ASYNC_GC, 32'h1);
        measure(32'(ssel));
        wr(ADDR_SDRAM_GC, 32'h1);
        probe_sel = 1;
        count_hi(k);
        check("buffered_input_clock_out_on", k > 0, 1'b1);
        wr(ADDR_REG_CTL, 32'h083);
        count_hi(k);
        check("buffered_input_clock_out_off", k, 32'h0);
        for (int s = 0; s < 4; s++)
            power_cycle(s);
        ext_mode <= 1'b1;
        do_reset();
        rd(ADDR_STATUS);
        check("ext_mode", r[1], 1'b1);
        check("oe_external", ss_oe, 1'b0);
        ramp <= 8'h02;
        power_cycle(0);
        ramp <= 8'h3C;
        power_cycle(3);
        stop_test();
    end
endmodule : testbench
